// ---- logic/qdsdb_cfg.svh ----
// Constants for the quad converter serial front end
`ifndef QDSDB_CFG_SVH
`define QDSDB_CFG_SVH
`define QDSDB_WORD_BITS 24
`define QDSDB_CODE_BITS 16
`define QDSDB_CHANNELS 4
`define QDSDB_SEL_HI_BIT 23
`define QDSDB_SEL_LO_BIT 22
`define QDSDB_BCAST_BIT 21
`define QDSDB_CODE_MSB 15
`define QDSDB_MID_CODE 16'h8000
`define QDSDB_ZERO_CODE 16'h0000
`define QDSDB_WORD_RST 24'h000000
`endif

// ---- logic/qdsdb_pkg.sv ----
// Types for the quad converter serial front end
package qdsdb_pkg;
	typedef logic [15:0] qdsdb_code_t;
	typedef struct packed {
		logic chip_sel_n;
		logic shift_clk;
		logic serial_in;
	} qdsdb_link_s;
	typedef struct packed {
		logic load_n;
		logic update;
		logic clear;
	} qdsdb_strobe_s;
endpackage

// ---- logic/qdsdb_core.sv ----
// Serial front end of a quad 16-bit converter, double buffered
`timescale 1ns/10ps
`include "qdsdb_cfg.svh"

// Function
// - 24-bit word: two select bits first, code last sixteen bits, msb first
// - Third bit high writes all four input registers, else only addressed one
// - Clear rising edge acts on every input and channel register
// - Clear loads 8000 hex if level select high, else 0000 hex
// - Shift one bit per rising edge of chip select OR shift clock
// - Chip select and shift clock are interchangeable shift sources
// - Chip select rising with clock low gives one extra shift
// - Chip select tied low lets shift clock alone shift
// - Input registers follow shift register while load strobe low
// - Shifting during load low corrupts registers selected along the way
// - Update strobe rising edge copies all input registers to channels
// - Input writes never alter channel registers
// - Clear leaves the shift register unchanged
// - Serial output is the last shift stage, always driven
// - Codes are straight unsigned binary
module qdsdb_core #(
	parameter int NCH = `QDSDB_CHANNELS
) (
	input  wire logic                    mclk_i,
	input  wire logic                    rstn_i,
	input  wire logic                    clk_en_i,
	input  wire qdsdb_pkg::qdsdb_link_s  link_i,
	input  wire qdsdb_pkg::qdsdb_strobe_s strobe_i,
	input  wire logic                    clear_level_select_i,
	output logic                         serial_out_o,
	output qdsdb_pkg::qdsdb_code_t       chan_code_o [NCH]
);

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Pins cross domains: three stages, a change counts once stages two and three agree
	localparam int NP = 6;
	logic [NP-1:0] raw;
	logic [NP-1:0] s1_q;
	logic [NP-1:0] s2_q;
	logic [NP-1:0] s3_q;
	logic [NP-1:0] flt_q;
	logic [NP-1:0] flt_d;
	assign raw = {link_i.chip_sel_n, link_i.shift_clk, link_i.serial_in,
		strobe_i.load_n, strobe_i.update, strobe_i.clear};

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
		end else if (clk_en_i) begin
			s1_q <= raw;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	always_comb begin
		for (int i = 0; i < NP; i++) begin
			flt_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : flt_q[i];
		end
	end

	// Filtered levels reset high on chip select and load; stages reset low, so both dip and rise again after reset
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			flt_q <= 6'h24;
		end else if (clk_en_i) begin
			flt_q <= flt_d;
		end
	end

	logic cs_n_f;
	logic sck_f;
	logic sdi_f;
	logic load_n_f;
	logic upd_f;
	logic clr_f;
	assign {cs_n_f, sck_f, sdi_f, load_n_f, upd_f, clr_f} = flt_q;

	// ----------------------------------------
	// Edge detection
	// ----------------------------------------
	logic gate_now;
	logic gate_prev;
	logic shift_ev;
	logic upd_ev;
	logic clr_ev;
	assign gate_now  = flt_d[5] | flt_d[4];
	assign gate_prev = cs_n_f | sck_f;
	assign shift_ev  = clk_en_i & gate_now & ~gate_prev;
	assign upd_ev    = clk_en_i & flt_d[1] & ~upd_f;
	assign clr_ev    = clk_en_i & flt_d[0] & ~clr_f;

	// ----------------------------------------
	// Shift register
	// ----------------------------------------
	logic [`QDSDB_WORD_BITS-1:0] shift_q;
	logic [`QDSDB_WORD_BITS-1:0] shift_d;
	// Data bit is sampled with the edge, as its filtered level at that cycle
	assign shift_d = {shift_q[`QDSDB_WORD_BITS-2:0], flt_d[3]};

	// Clear does not touch this register
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shift_q <= `QDSDB_WORD_RST;
		end else if (shift_ev) begin
			shift_q <= shift_d;
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			serial_out_o <= 1'b0;
		end else if (clk_en_i) begin
			serial_out_o <= shift_d[`QDSDB_WORD_BITS-1] & shift_ev
				| shift_q[`QDSDB_WORD_BITS-1] & ~shift_ev;
		end
	end

	// ----------------------------------------
	// Input and channel registers
	// ----------------------------------------
	logic [1:0]             sel;
	logic                   bcast;
	qdsdb_pkg::qdsdb_code_t code;
	qdsdb_pkg::qdsdb_code_t clr_code;
	qdsdb_pkg::qdsdb_code_t in_q [NCH];
	// Latch tracks the current shift content each cycle, so it follows mid-word
	assign sel   = {shift_q[`QDSDB_SEL_HI_BIT], shift_q[`QDSDB_SEL_LO_BIT]};
	assign bcast = shift_q[`QDSDB_BCAST_BIT];
	assign code  = shift_q[`QDSDB_CODE_MSB:0];
	assign clr_code = clear_level_select_i ? `QDSDB_MID_CODE : `QDSDB_ZERO_CODE;

	// Clear level select is sampled on the clock; host holds it steady around clear
	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NCH; i++) begin
				in_q[i] <= `QDSDB_ZERO_CODE;
			end
		end else if (clr_ev) begin
			for (int i = 0; i < NCH; i++) begin
				in_q[i] <= clr_code;
			end
		end else if (clk_en_i && !load_n_f) begin
			for (int i = 0; i < NCH; i++) begin
				if (bcast || sel == i[1:0]) begin
					in_q[i] <= code;
				end
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			for (int i = 0; i < NCH; i++) begin
				chan_code_o[i] <= `QDSDB_ZERO_CODE;
			end
		end else if (clr_ev) begin
			for (int i = 0; i < NCH; i++) begin
				chan_code_o[i] <= clr_code;
			end
		end else if (upd_ev) begin
			for (int i = 0; i < NCH; i++) begin
				chan_code_o[i] <= in_q[i];
			end
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	shift_step_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		shift_ev |=> shift_q == {$past(shift_q[`QDSDB_WORD_BITS-2:0]), $past(flt_d[3])})
		else $error("shift did not advance one bit");
	shift_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(cs_n_f && flt_d[5] && clk_en_i) |=> $stable(shift_q))
		else $error("shift changed with chip select high");
	extra_edge_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(clk_en_i && !gate_prev && flt_d[5] && !flt_d[4]) |-> shift_ev)
		else $error("chip select rise missed a shift");
	clr_keep_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(clr_ev && !shift_ev) |=> $stable(shift_q))
		else $error("clear altered shift register");
	clr_chan_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		clr_ev |=> chan_code_o[0] == (clear_level_select_i ? 16'h8000 : 16'h0000)
			&& in_q[3] == chan_code_o[0])
		else $error("clear code wrong");
	update_copy_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(upd_ev && !clr_ev) |=> chan_code_o[1] == $past(in_q[1]))
		else $error("update did not copy input register");
	chan_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(!upd_ev && !clr_ev) |=> $stable(chan_code_o[2]))
		else $error("channel changed without update");
	latch_follow_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(clk_en_i && !load_n_f && !clr_ev && bcast) |=> in_q[0] == $past(code)
			&& in_q[3] == $past(code))
		else $error("broadcast write missed");
	latch_hold_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		(load_n_f && !clr_ev) |=> $stable(in_q[1]))
		else $error("input register changed with load high");
	sout_last_a: assert property (@(posedge mclk_i) disable iff (!rstn_i)
		clk_en_i |=> serial_out_o == shift_q[`QDSDB_WORD_BITS-1])
		else $error("serial output not last stage");

	shift_c: cover property (@(posedge mclk_i) disable iff (!rstn_i) shift_ev);
	update_c: cover property (@(posedge mclk_i) disable iff (!rstn_i) upd_ev);
	clear_mid_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		clr_ev && clear_level_select_i);
	bcast_c: cover property (@(posedge mclk_i) disable iff (!rstn_i)
		!load_n_f && bcast);

endmodule

// ---- verification/qdsdb_host.sv ----
// Host model driving the serial link and the strobes
`timescale 1ns/10ps
module qdsdb_host (
	input  wire logic                mclk_i,
	output qdsdb_pkg::qdsdb_link_s   link_o,
	output qdsdb_pkg::qdsdb_strobe_s strobe_o
);
	// ----------
	// Link and strobe tasks
	// ----------
	initial begin
		link_o = 3'b110;
		strobe_o = 3'b100;
	end

	task automatic hold(input int n);
		repeat (n) @(posedge mclk_i);
	endtask

	// Mode 1 drops the clock before release, mode 2 keeps select low
	task automatic send(input logic [23:0] w, input int mode);
		link_o.chip_sel_n <= 1'b0;
		hold(4);
		for (int i = 23; i >= 0; i--) begin
			link_o.shift_clk <= 1'b0;
			link_o.serial_in <= w[i];
			hold(4);
			link_o.shift_clk <= 1'b1;
			hold(4);
		end
		if (mode == 1) begin
			link_o.shift_clk <= 1'b0;
			hold(4);
		end
		if (mode != 2) link_o.chip_sel_n <= 1'b1;
		// Released data must not look like the last bit
		link_o.serial_in <= ~w[0];
		hold(4);
		link_o.shift_clk <= 1'b1;
		hold(4);
	endtask

	// Bit 2 load, 1 update, 0 clear; levels held well past the pin filter
	task automatic pulse(input int k);
		strobe_o[k] <= ~strobe_o[k];
		hold(6);
		strobe_o[k] <= ~strobe_o[k];
		hold(6);
	endtask
endmodule

// ---- verification/qdsdb_core_bench.sv ----
// Self-checking bench for the quad converter serial front end
`timescale 1ns/10ps
module qdsdb_core_bench;
	localparam logic [15:0] CODES [4] = '{16'hFFFF, 16'h0001, 16'h8000, 16'h7FFE};
	logic                     mclk_i = 1'b0;
	logic                     rstn_i = 1'b0;
	logic                     clk_en_i = 1'b1;
	logic                     clear_level_select_i = 1'b0;
	logic                     serial_out;
	qdsdb_pkg::qdsdb_link_s   link;
	qdsdb_pkg::qdsdb_strobe_s strobe;
	qdsdb_pkg::qdsdb_code_t   chan [4];
	int                       err_count = 0;
	int                       compares = 0;

	always #25 mclk_i = ~mclk_i;

	qdsdb_host u_host (.mclk_i(mclk_i), .link_o(link), .strobe_o(strobe));

	qdsdb_core u_dut (
		.mclk_i(mclk_i), .rstn_i(rstn_i), .clk_en_i(clk_en_i), .link_i(link),
		.strobe_i(strobe), .clear_level_select_i(clear_level_select_i),
		.serial_out_o(serial_out), .chan_code_o(chan)
	);

	// ------------
	// Check helpers
	// ------------
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude();
		if (err_count == 0 && compares > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Polls under a bound; channel latency is only approximate
	task automatic expect_ch(input int i, input logic [15:0] exp);
		int n;
		n = 0;
		while (chan[i] !== exp && n < 20) begin
			@(posedge mclk_i);
			n++;
		end
		check(chan[i], exp);
		if (n == 20) conclude();
	endtask

	// --------
	// Sequence
	// --------
	initial begin
		repeat (2) @(posedge mclk_i);
		rstn_i <= 1'b1;
		repeat (4) @(posedge mclk_i);
		// Stage all channels with boundary codes and ignored bits set
		for (int c = 0; c < 4; c++) begin
			u_host.send({c[1:0], 1'b0, 5'h1F, CODES[c]}, 0);
			check(serial_out, c[1]);
			u_host.pulse(2);
		end
		for (int c = 0; c < 4; c++) check(chan[c], 16'h0000);
		// Frozen block must miss an update strobe entirely
		clk_en_i <= 1'b0;
		u_host.pulse(1);
		check(chan[0], 16'h0000);
		clk_en_i <= 1'b1;
		@(posedge mclk_i);
		check(chan[1], 16'h0000);
		u_host.pulse(1);
		for (int c = 0; c < 4; c++) expect_ch(c, CODES[c]);
		// Broadcast with select held low throughout
		u_host.send({2'b10, 1'b1, 5'h00, 16'hA55A}, 2);
		u_host.pulse(2);
		check(chan[0], CODES[0]);
		u_host.pulse(1);
		for (int c = 0; c < 4; c++) expect_ch(c, 16'hA55A);
		// First update after each clear proves the input registers were cleared too
		for (int s = 1; s >= 0; s--) begin
			clear_level_select_i <= s[0];
			@(posedge mclk_i);
			u_host.pulse(0);
			for (int u = 0; u < 2; u++) begin
				for (int c = 0; c < 4; c++) expect_ch(c, s[0] ? 16'h8000 : 16'h0000);
				u_host.pulse(1);
			end
			check(serial_out, 1'b1);
		end
		// Select released with the clock low shifts once more
		u_host.send(24'h4F00F0, 1);
		check(serial_out, 1'b1);
		conclude();
	end
endmodule
